/* File: rtl/scsd_top.sv */
// System clock source select, power-of-two divider and internal oscillator control.
// Assumes a one-cycle register strobe port on mclk and slow oscillator clocks on pins.
//
// Summary of operation
// - Divide selected source by 1 to 128
// - New ratio applied within 128 source cycles
// - Bit 7 reads divider applied flag
// - Source switch on new source edge after an old source edge
// - Divide code n gives two to n
// - Source codes 000,001,011,100; rest reserved
// - Bit 3 reads zero, written zero
// - Control bit 7 enables internal oscillator
// - Bit 6 reads oscillator frequency ready
// - Trim bit 7 enables spread dithering
// - Larger trim lowers oscillator frequency
// - Trim resets to factory calibration value
`timescale 1ns/10ps
`default_nettype none
module scsd_top
   import scsd_pkg::*;
#(
   parameter logic [6:0] TRIM_FACTORY = 7'h40,
   parameter logic [5:0] RESV_RESET   = 6'h00
)
(
   input  wire logic                    mclk,
   input  wire logic                    reset_n,
   input  wire logic [7:0]              sfr_addr,
   input  wire logic [7:0]              sfr_wdata,
   input  wire logic                    sfr_wr,
   input  wire logic                    sfr_rd,
   output logic      [7:0]              sfr_rdata,
   input  wire logic [SCSD_NUM_SRC-1:0] osc_clk_in,
   input  wire logic                    osc_freq_ok_in,
   output logic                         sys_clk_tick,
   output logic      [1:0]              sys_src_index,
   output logic      [2:0]              sys_div_applied,
   output logic                         src_switching,
   output logic                         internal_osc_on,
   output logic                         spread_dither_on,
   output logic      [6:0]              internal_osc_trim
);

   typedef struct packed {
      scsd_state_e           st;
      logic [2:0]            div_code;
      logic [2:0]            sel_code;
      logic [2:0]            div_applied;
      logic                  ready;
      logic [1:0]            cur_src;
      logic [1:0]            new_src;
      logic [SCSD_PRE_W-1:0] pre_cnt;
      logic                  osc_on;
      logic [5:0]            osc_resv;
      logic                  dither;
      logic [6:0]            trim;
      logic                  freq_ok;
      logic                  tick;
      logic                  switching;
      logic [7:0]            rdata;
   } scsd_top_s;

   // Reset state of the top-level registers (the u_sync stages reset to zero on their own)
   localparam scsd_top_s RESET_Q = '{
      st:          SCSD_RUN,
      div_code:    SCSD_CSD_RESET[SCSD_DIV_MSB:SCSD_DIV_LSB],
      sel_code:    SCSD_CSD_RESET[SCSD_SEL_MSB:SCSD_SEL_LSB],
      div_applied: SCSD_CSD_RESET[SCSD_DIV_MSB:SCSD_DIV_LSB],
      ready:       SCSD_CSD_RESET[SCSD_READY_BIT],
      cur_src:     2'h3,
      new_src:     2'h3,
      pre_cnt:     '0,
      osc_on:      SCSD_OSC_ON_RESET,
      osc_resv:    RESV_RESET,
      dither:      SCSD_DITHER_RESET,
      trim:        TRIM_FACTORY,
      freq_ok:     1'b0,
      tick:        1'b0,
      switching:   1'b0,
      rdata:       8'h00
   };

   function automatic logic scsd_src_valid(input logic [2:0] code);
      scsd_src_valid = (code == SCSD_SEL_PRECISION) || (code == SCSD_SEL_EXTERNAL) ||
                       (code == SCSD_SEL_RTC) || (code == SCSD_SEL_LOW_POWER);
   endfunction : scsd_src_valid

   function automatic logic [1:0] scsd_src_index(input logic [2:0] code);
      case (code)
         SCSD_SEL_PRECISION: scsd_src_index = 2'h0;
         SCSD_SEL_EXTERNAL:  scsd_src_index = 2'h1;
         SCSD_SEL_RTC:       scsd_src_index = 2'h2;
         default:            scsd_src_index = 2'h3;
      endcase
   endfunction : scsd_src_index

   function automatic logic [SCSD_PRE_W-1:0] scsd_div_mask(input logic [2:0] code);
      scsd_div_mask = SCSD_PRE_LAST >> (3'h7 - code);
   endfunction : scsd_div_mask

   scsd_edge_if edge_if ();

   scsd_src_sync u_sync (
      .mclk           (mclk),
      .reset_n        (reset_n),
      .osc_clk_in     (osc_clk_in),
      .osc_freq_ok_in (osc_freq_ok_in),
      .edge_if        (edge_if)
   );

   scsd_top_s             q_ff;
   scsd_top_s             nxt_q;
   logic                  cur_edge;
   logic                  new_edge;
   logic [SCSD_PRE_W-1:0] div_mask;
   logic [1:0]            wr_src;
   logic [2:0]            wr_div;
   logic [2:0]            wr_sel;

   assign cur_edge = edge_if.src_edge[q_ff.cur_src];
   assign new_edge = edge_if.src_edge[q_ff.new_src];
   assign div_mask = scsd_div_mask(q_ff.div_applied);
   assign wr_div   = sfr_wdata[SCSD_DIV_MSB:SCSD_DIV_LSB];
   assign wr_sel   = sfr_wdata[SCSD_SEL_MSB:SCSD_SEL_LSB];
   assign wr_src   = scsd_src_index(q_ff.sel_code);

   always_comb begin
      nxt_q      = q_ff;
      nxt_q.tick = 1'b0;

      case (q_ff.st)
         SCSD_RUN: begin
            if (cur_edge) begin
               nxt_q.pre_cnt = q_ff.pre_cnt + 7'h01;
               if ((q_ff.pre_cnt & div_mask) == div_mask) begin
                  nxt_q.tick = 1'b1;
               end
               if (q_ff.pre_cnt == SCSD_PRE_LAST && !q_ff.ready) begin
                  nxt_q.div_applied = q_ff.div_code;
                  nxt_q.ready       = 1'b1;
               end
            end
            if (scsd_src_valid(q_ff.sel_code) && wr_src != q_ff.cur_src) begin
               nxt_q.new_src = wr_src;
               nxt_q.st      = SCSD_WAIT_OLD;
            end
         end
         SCSD_WAIT_OLD: begin
            if (cur_edge) begin
               nxt_q.st = SCSD_WAIT_NEW;
            end
         end
         SCSD_WAIT_NEW: begin
            if (new_edge) begin
               nxt_q.cur_src = q_ff.new_src;
               nxt_q.pre_cnt = '0;
               nxt_q.st      = SCSD_RUN;
            end
         end
         default: begin
            nxt_q.st = SCSD_RUN;
         end
      endcase

      nxt_q.switching = (nxt_q.st != SCSD_RUN);

      nxt_q.freq_ok = q_ff.osc_on & edge_if.freq_ok;

      if (sfr_wr) begin
         case (sfr_addr)
            SCSD_ADDR_CLOCK_SELECT_DIVIDER: begin
               nxt_q.div_code = wr_div;
               nxt_q.sel_code = wr_sel;
               nxt_q.ready    = (wr_div == nxt_q.div_applied);
            end
            SCSD_ADDR_INTERNAL_OSC_CONTROL: begin
               nxt_q.osc_on   = sfr_wdata[SCSD_OSC_ON_BIT];
               nxt_q.osc_resv = sfr_wdata[SCSD_RESV_MSB:0];
            end
            SCSD_ADDR_INTERNAL_OSC_TRIM: begin
               nxt_q.dither = sfr_wdata[SCSD_DITHER_BIT];
               nxt_q.trim   = sfr_wdata[SCSD_TRIM_MSB:0];
            end
            default: begin
               nxt_q.osc_on = nxt_q.osc_on;
            end
         endcase
      end

      nxt_q.rdata = 8'h00;
      if (sfr_rd) begin
         case (sfr_addr)
            SCSD_ADDR_CLOCK_SELECT_DIVIDER: begin
               nxt_q.rdata = {q_ff.ready, q_ff.div_code, 1'b0, q_ff.sel_code};
            end
            SCSD_ADDR_INTERNAL_OSC_CONTROL: begin
               nxt_q.rdata = {q_ff.osc_on, q_ff.freq_ok, q_ff.osc_resv};
            end
            SCSD_ADDR_INTERNAL_OSC_TRIM: begin
               nxt_q.rdata = {q_ff.dither, q_ff.trim};
            end
            default: begin
               nxt_q.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q_ff <= RESET_Q;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign sfr_rdata         = q_ff.rdata;
   assign sys_clk_tick      = q_ff.tick;
   assign sys_src_index     = q_ff.cur_src;
   assign sys_div_applied   = q_ff.div_applied;
   assign src_switching     = q_ff.switching;
   assign internal_osc_on   = q_ff.osc_on;
   assign spread_dither_on  = q_ff.dither;
   assign internal_osc_trim = q_ff.trim;

endmodule : scsd_top
`default_nettype wire

/* File: rtl/scsd_pkg.sv */
// Constants and types shared by the clock select and divide block.
// Assumes one clock (mclk) and an 8-bit special function register port.
package scsd_pkg;

   // Register addresses on the special function register port
   localparam logic [7:0] SCSD_ADDR_CLOCK_SELECT_DIVIDER = 8'hA9;
   localparam logic [7:0] SCSD_ADDR_INTERNAL_OSC_CONTROL = 8'hB2;
   localparam logic [7:0] SCSD_ADDR_INTERNAL_OSC_TRIM    = 8'hB3;

   // Clock select and divide register layout
   localparam int         SCSD_READY_BIT    = 7;
   localparam int         SCSD_DIV_MSB      = 6;
   localparam int         SCSD_DIV_LSB      = 4;
   localparam int         SCSD_SEL_MSB      = 2;
   localparam int         SCSD_SEL_LSB      = 0;
   localparam logic [7:0] SCSD_CSD_RESET    = 8'h34;

   // Internal oscillator control and trim layouts
   localparam int         SCSD_OSC_ON_BIT   = 7;
   localparam int         SCSD_FREQ_OK_BIT  = 6;
   localparam int         SCSD_RESV_MSB     = 5;
   localparam int         SCSD_DITHER_BIT   = 7;
   localparam int         SCSD_TRIM_MSB     = 6;
   localparam logic       SCSD_OSC_ON_RESET = 1'b0;
   localparam logic       SCSD_DITHER_RESET = 1'b0;

   // Source select codes
   localparam logic [2:0] SCSD_SEL_PRECISION = 3'h0;
   localparam logic [2:0] SCSD_SEL_EXTERNAL  = 3'h1;
   localparam logic [2:0] SCSD_SEL_RTC       = 3'h3;
   localparam logic [2:0] SCSD_SEL_LOW_POWER = 3'h4;

   // Number of oscillator sources and prescaler width
   localparam int         SCSD_NUM_SRC      = 4;
   localparam int         SCSD_PRE_W        = 7;
   localparam logic [6:0] SCSD_PRE_LAST     = 7'h7F;

   // Source switch sequencer
   typedef enum logic [2:0] {
      SCSD_RUN      = 3'b001,
      SCSD_WAIT_OLD = 3'b010,
      SCSD_WAIT_NEW = 3'b100
   } scsd_state_e;

endpackage : scsd_pkg

/* File: rtl/scsd_edge_if.sv */
// Carries synchronised oscillator edges and the frequency-ready level.
// Assumes both ends run on mclk.
`timescale 1ns/10ps
`default_nettype none
interface scsd_edge_if;
   logic [3:0] src_edge;
   logic       freq_ok;
   modport drv (output src_edge, output freq_ok);
   modport rcv (input src_edge, input freq_ok);
endinterface : scsd_edge_if
`default_nettype wire

/* File: rtl/scsd_src_sync.sv */
// Synchronises the oscillator clocks and the frequency-ready level into mclk.
// Assumes source clocks are far slower than mclk (below mclk/4).
`timescale 1ns/10ps
`default_nettype none
module scsd_src_sync
   import scsd_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    reset_n,
   input  wire logic [SCSD_NUM_SRC-1:0] osc_clk_in,
   input  wire logic                    osc_freq_ok_in,
   scsd_edge_if.drv                     edge_if
);

   typedef struct packed {
      logic [SCSD_NUM_SRC:0]   s1;
      logic [SCSD_NUM_SRC:0]   s2;
      logic [SCSD_NUM_SRC-1:0] s3;
      logic [SCSD_NUM_SRC-1:0] rise;
   } scsd_sync_s;

   scsd_sync_s q_ff;
   scsd_sync_s nxt_q;

   always_comb begin
      nxt_q    = q_ff;
      nxt_q.s1 = {osc_freq_ok_in, osc_clk_in};
      nxt_q.s2 = q_ff.s1;
      nxt_q.s3 = q_ff.s2[SCSD_NUM_SRC-1:0];
      for (int i = 0; i < SCSD_NUM_SRC; i++) begin
         nxt_q.rise[i] = q_ff.s2[i] & ~q_ff.s3[i];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign edge_if.src_edge = q_ff.rise;
   assign edge_if.freq_ok  = q_ff.s2[SCSD_NUM_SRC];

endmodule : scsd_src_sync
`default_nettype wire

/* File: test/scsd_chk.sv */
// Port checks for the clock select and divide block.
// Assumes it is bound to scsd_top and runs on mclk.
`timescale 1ns/10ps
`default_nettype none
module scsd_chk (
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic [3:0] osc_clk_in,
   input wire logic       osc_freq_ok_in,
   input wire logic       sys_clk_tick,
   input wire logic [1:0] sys_src_index,
   input wire logic [2:0] sys_div_applied,
   input wire logic       src_switching,
   input wire logic       internal_osc_on,
   input wire logic       spread_dither_on,
   input wire logic [6:0] internal_osc_trim
);
   logic rd_cs, wr_cs, rd_oc, wr_oc, wr_tr;
   assign rd_cs = sfr_rd && sfr_addr == 8'hA9;
   assign wr_cs = sfr_wr && sfr_addr == 8'hA9;
   assign rd_oc = sfr_rd && sfr_addr == 8'hB2;
   assign wr_oc = sfr_wr && sfr_addr == 8'hB2;
   assign wr_tr = sfr_wr && sfr_addr == 8'hB3;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   chk_spare_bit_zero: assert property (rd_cs |=> !sfr_rdata[3])
      else $error("spare bit read one");
   chk_osc_enable: assert property (wr_oc |=> internal_osc_on == $past(sfr_wdata[7]))
      else $error("osc enable mismatch");
   chk_flag_off: assert property (
      rd_oc && !internal_osc_on && !$past(internal_osc_on) |=> !sfr_rdata[6])
      else $error("freq flag with osc off");
   chk_dither_write: assert property (wr_tr |=> spread_dither_on == $past(sfr_wdata[7]))
      else $error("dither mismatch");
   chk_trim_write: assert property (wr_tr |=> internal_osc_trim == $past(sfr_wdata[6:0]))
      else $error("trim mismatch");
   chk_src_change: assert property ($changed(sys_src_index) |-> $past(src_switching))
      else $error("source changed outside switch");
   chk_ready_clear: assert property (
      wr_cs && sfr_wdata[6:4] != sys_div_applied ##2 rd_cs |=> !sfr_rdata[7])
      else $error("ready not cleared");
   chk_ready_code: assert property (
      rd_cs && !wr_cs && !$past(wr_cs)
      |=> !sfr_rdata[7] || sfr_rdata[6:4] == $past(sys_div_applied))
      else $error("ready with code not applied");
   chk_no_tick_switch: assert property ($past(src_switching) |-> !sys_clk_tick)
      else $error("tick during source switch");
   cov_tick: cover property (sys_clk_tick);
   cov_switch: cover property ($rose(src_switching));
   cov_apply: cover property ($changed(sys_div_applied));
endmodule : scsd_chk
bind scsd_top scsd_chk u_chk (.*);
`default_nettype wire

/* File: test/tb_scsd.sv */
// Self-checking bench for the clock select and divide block.
// Assumes free-running oscillator pins far slower than mclk.
`timescale 1ns/10ps
`default_nettype none
module tb_scsd;
   logic       mclk      = 1'b0;
   logic       reset_n   = 1'b0;
   logic [7:0] sfr_addr  = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic       sfr_wr    = 1'b0;
   logic       sfr_rd    = 1'b0;
   logic       osc0 = 1'b0, osc1 = 1'b0, osc2 = 1'b0, osc3 = 1'b0;
   logic       freq_ok   = 1'b0;
   logic [7:0] rdata, rv, cnt;
   logic       tick, swt, osc_on, dith, prv;
   logic [1:0] src;
   logic [2:0] div;
   logic [6:0] trim;
   int         fail_count  = 0;
   int         check_count = 0;
   logic [2:0] sels [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h5, 3'h6, 3'h7, 3'h4};
   logic [1:0] idxs [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
   always #5 mclk = ~mclk;
   always #40 osc3 = ~osc3;
   always #50 osc0 = ~osc0;
   always #60 osc1 = ~osc1;
   always #100 osc2 = ~osc2;
   // Low power oscillator edges since the last tick
   always @(posedge mclk) begin
      prv <= osc3;
      cnt <= (tick ? 8'h00 : cnt) + {7'h00, osc3 & ~prv};
   end
   scsd_top u_dut (
      .mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(rdata),
      .osc_clk_in({osc3, osc2, osc1, osc0}),
      .osc_freq_ok_in(freq_ok), .sys_clk_tick(tick), .sys_src_index(src),
      .sys_div_applied(div), .src_switching(swt), .internal_osc_on(osc_on),
      .spread_dither_on(dith), .internal_osc_trim(trim)
   );
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      cyc(1);
      sfr_wr = 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr = a;
      sfr_rd = 1'b1;
      cyc(1);
      sfr_rd = 1'b0;
      d = rdata;
      cyc(1);
   endtask : rd
   task automatic wait_tick();
      cyc(1);
      repeat (2000) if (tick !== 1'b1) cyc(1);
   endtask : wait_tick
   task automatic give_verdict();
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   initial begin
      #900us;
      fail_count++;
      give_verdict();
   end
   initial begin
      cyc(6);
      reset_n = 1'b1;
      cyc(1);
      rd(8'hA9, rv);
      chk8("select reset", 8'h34, rv);
      rd(8'hB3, rv);
      chk8("trim reset", 8'h40, rv);
      freq_ok = 1'b1;
      rd(8'hB2, rv);
      chk8("flag osc off", 8'h00, rv);
      wr(8'hB2, rv | 8'h80);
      chk8("osc on", 8'h01, {7'h00, osc_on});
      cyc(5);
      rd(8'hB2, rv);
      chk8("flag osc on", 8'hC0, rv);
      freq_ok = 1'b0;
      cyc(5);
      rd(8'hB2, rv);
      chk8("flag pin low", 8'h80, rv);
      wr(8'hB2, rv & 8'h7F);
      chk8("osc off", 8'h00, {7'h00, osc_on});
      wr(8'hB3, 8'hC5);
      chk8("dither trim", 8'hC5, {dith, trim});
      rd(8'hB3, rv);
      chk8("trim read", 8'hC5, rv);
      for (int k = 0; k < 8; k++) begin
         wr(8'hA9, {1'b0, k[2:0], 4'h4});
         rd(8'hA9, rv);
         chk8("ready cleared", 8'h00, {7'h00, rv[7]});
         repeat (530) if (rv[7] !== 1'b1) rd(8'hA9, rv);
         chk8("ready set", {1'b1, k[2:0], 4'h4}, rv);
         chk8("div code", {5'h00, k[2:0]}, {5'h00, div});
         wait_tick();
         wait_tick();
         chk8("edges per tick", 8'h01 << k, cnt);
      end
      foreach (sels[i]) begin
         wr(8'hA9, {5'h00, sels[i]});
         chk8("switching", {7'h00, idxs[i] != idxs[(i + 7) % 8]}, {7'h00, swt});
         cyc(80);
         chk8("switch done", 8'h00, {7'h00, swt});
         chk8("source", {6'h00, idxs[i]}, {6'h00, src});
         rd(8'hA9, rv);
         chk8("select field", {5'h00, sels[i]}, rv & 8'h0F);
      end
      give_verdict();
   end
endmodule : tb_scsd
`default_nettype wire
